// file: core/psm_pkg.sv
/*
 Package of the supply monitor flag logic: register address, field
 positions, reset values, threshold codes, timing constants, types.
 Assumes a 250 MHz core clock and an 8-bit special-function register port.

*/
package psm_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] PSM_CTRL_ADDR  = 8'hDF;
   localparam logic [7:0] PSM_CTRL_RESET = 8'hDE;
   localparam int         BIT_DIG_OK     = 7;
   localparam int         BIT_ANA_OK     = 6;
   localparam int         BIT_FLAG       = 5;
   localparam int         BIT_DTH_HI     = 4;
   localparam int         BIT_DTH_LO     = 3;
   localparam int         BIT_ATH_HI     = 2;
   localparam int         BIT_ATH_LO     = 1;
   localparam int         BIT_ENABLE     = 0;

   // ------------------------------------------------------------
   // Threshold codes (millivolts per code)
   // ------------------------------------------------------------
   localparam logic [1:0] TH_4V63 = 2'h0;
   localparam logic [1:0] TH_3V08 = 2'h1;
   localparam logic [1:0] TH_2V93 = 2'h2;
   localparam logic [1:0] TH_2V63 = 2'h3;
   localparam logic [1:0] TH_RESET = 2'h3;
   localparam int TH_MV [4] = '{4630, 3080, 2930, 2630};

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int  CLK_MHZ        = 250;
   localparam int  RECOVER_MS     = 250;
   localparam longint RECOVER_CYC = longint'(RECOVER_MS) * 1000 * CLK_MHZ;
   localparam int  GLITCH_NS      = 100;
   localparam int  GLITCH_CYC     = (GLITCH_NS * CLK_MHZ) / 1000;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic       wrEn;
      logic [7:0] addr;
      logic [7:0] wdata;
   } psm_sfr_req_s;

   typedef struct packed {
      logic digOk;
      logic anaOk;
   } psm_cmp_s;

   typedef enum logic [1:0] {PSM_IDLE, PSM_LOW, PSM_COUNT} psm_state_e;

endpackage

// file: core/psm_deglitch.sv
/*
 Glitch filter for one comparator output: the output follows the input only
 after it has been stable for a set number of clocks.
 Assumes the comparator input is synchronous to clk.
*/
module psm_deglitch #(
   parameter int STABLE_CYC = psm_pkg::GLITCH_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Comparator
   input  wire logic rawOk,
   output logic      filtOk
);
   import psm_pkg::*;

   localparam int CW = $clog2(STABLE_CYC + 1);

   if (STABLE_CYC < 1) begin : g_bad_cyc
      $error("STABLE_CYC must be at least 1");
   end

   typedef struct packed {
      logic          out;
      logic [CW-1:0] cnt;
   } psm_dg_s;

   psm_dg_s state_ff;
   psm_dg_s nxt_state;

   always_comb begin
      nxt_state = state_ff;
      if (rawOk == state_ff.out) begin
         nxt_state.cnt = '0;
      end else if (state_ff.cnt == CW'(STABLE_CYC - 1)) begin
         nxt_state.out = rawOk;
         nxt_state.cnt = '0;
      end else begin
         nxt_state.cnt = state_ff.cnt + CW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= '{out: 1'b1, cnt: '0};
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign filtOk = state_ff.out;
endmodule

// file: core/psm_recover_timer.sv
/*
 Recovery timer: counts while run is high, restarts when run drops,
 and pulses done for one cycle each time the count reaches its length.
 Assumes run is a clean level in the clk domain.
*/
module psm_recover_timer #(
   parameter longint COUNT_CYC = psm_pkg::RECOVER_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Control
   input  wire logic run,
   output logic      done
);
   import psm_pkg::*;

   localparam int CW = $clog2(COUNT_CYC + 1);

   if (COUNT_CYC < 2) begin : g_bad_cyc
      $error("COUNT_CYC must be at least 2");
   end

   typedef struct packed {
      logic          done;
      logic [CW-1:0] cnt;
   } psm_tm_s;

   psm_tm_s state_ff;
   psm_tm_s nxt_state;

   always_comb begin
      nxt_state = state_ff;
      nxt_state.done = 1'b0;
      if (!run) begin
         nxt_state.cnt = '0;
      end else if (state_ff.cnt == CW'(COUNT_CYC - 1)) begin
         nxt_state.done = 1'b1;
         nxt_state.cnt  = '0;
      end else begin
         nxt_state.cnt = state_ff.cnt + CW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign done = state_ff.done;
endmodule

// file: core/psm_supply_monitor.sv
/*
 Supply monitor flag logic: control register at its special-function
 address, deglitched comparators, sticky fail flag with timed recovery,
 and an interrupt request gated by an outside enable.
 Assumes comparator outputs and register strobes are synchronous to clk;
 the analog comparators take the threshold codes driven out here.
*/
module psm_supply_monitor #(
   parameter longint RECOVER_CYC = psm_pkg::RECOVER_CYC,
   parameter int     GLITCH_CYC  = psm_pkg::GLITCH_CYC
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // Register port
   input  wire psm_pkg::psm_sfr_req_s sfrReq,
   output logic [7:0]                 sfrRdata,
   // Comparators
   input  wire psm_pkg::psm_cmp_s     cmpRaw,
   output logic [1:0]                 digThreshold,
   output logic [1:0]                 analogThreshold,
   output logic                       monitorEnable,
   // Interrupt
   input  wire logic                  secondaryIrqEnablePriority,
   output logic                       supplyFailIrq
);
   import psm_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic       flag;
      logic [1:0] dTh;
      logic [1:0] aTh;
      logic       en;
      psm_state_e fsm;
   } psm_ctl_s;

   psm_ctl_s ctl_ff;
   psm_ctl_s nxt_ctl;
   logic     digOk;
   logic     anaOk;
   logic     bothOk;
   logic     timerRun;
   logic     timerDone;
   logic     wrCtrl;

   // ------------------------------------------------------------
   // Comparator filtering
   // ------------------------------------------------------------
   psm_deglitch #(.STABLE_CYC(GLITCH_CYC)) u_dig (
      .clk    (clk),
      .rst    (rst),
      .rawOk  (cmpRaw.digOk),
      .filtOk (digOk)
   );

   psm_deglitch #(.STABLE_CYC(GLITCH_CYC)) u_ana (
      .clk    (clk),
      .rst    (rst),
      .rawOk  (cmpRaw.anaOk),
      .filtOk (anaOk)
   );

   // ------------------------------------------------------------
   // Recovery timer
   // ------------------------------------------------------------
   assign bothOk   = digOk && anaOk;
   assign timerRun = ctl_ff.en && bothOk && (ctl_ff.fsm == PSM_COUNT);

   psm_recover_timer #(.COUNT_CYC(RECOVER_CYC)) u_tmr (
      .clk  (clk),
      .rst  (rst),
      .run  (timerRun),
      .done (timerDone)
   );

   // ------------------------------------------------------------
   // Control and flag
   // ------------------------------------------------------------
   assign wrCtrl = sfrReq.wrEn && (sfrReq.addr == PSM_CTRL_ADDR);

   always_comb begin
      nxt_ctl = ctl_ff;
      if (wrCtrl) begin
         nxt_ctl.en  = sfrReq.wdata[BIT_ENABLE];
         nxt_ctl.dTh = sfrReq.wdata[BIT_DTH_HI:BIT_DTH_LO];
         nxt_ctl.aTh = sfrReq.wdata[BIT_ATH_HI:BIT_ATH_LO];
         // Software may set the flag; a clear takes only while both rails read high
         if (sfrReq.wdata[BIT_FLAG] || bothOk) begin
            nxt_ctl.flag = sfrReq.wdata[BIT_FLAG];
         end
      end
      unique case (ctl_ff.fsm)
         PSM_IDLE: begin
            if (ctl_ff.en && !bothOk) begin
               nxt_ctl.fsm = PSM_LOW;
            end
         end
         PSM_LOW: begin
            if (!ctl_ff.en) begin
               nxt_ctl.fsm = PSM_IDLE;
            end else if (bothOk) begin
               nxt_ctl.fsm = PSM_COUNT;
            end
         end
         PSM_COUNT: begin
            if (!ctl_ff.en) begin
               nxt_ctl.fsm = PSM_IDLE;
            end else if (!bothOk) begin
               nxt_ctl.fsm = PSM_LOW;
            end else if (timerDone) begin
               nxt_ctl.fsm = PSM_IDLE;
               // A software set in the same cycle wins over the timed clear
               if (!(wrCtrl && sfrReq.wdata[BIT_FLAG])) begin
                  nxt_ctl.flag = 1'b0;
               end
            end
         end
      endcase
      // Hardware set wins over any clear in the same cycle
      if (ctl_ff.en && !bothOk) begin
         nxt_ctl.flag = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_ff.flag <= PSM_CTRL_RESET[BIT_FLAG];
         ctl_ff.dTh  <= TH_RESET;
         ctl_ff.aTh  <= TH_RESET;
         ctl_ff.en   <= PSM_CTRL_RESET[BIT_ENABLE];
         ctl_ff.fsm  <= PSM_IDLE;
      end else begin
         ctl_ff <= nxt_ctl;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   always_comb begin
      sfrRdata             = 8'h00;
      sfrRdata[BIT_DIG_OK] = digOk;
      sfrRdata[BIT_ANA_OK] = anaOk;
      sfrRdata[BIT_FLAG]   = ctl_ff.flag;
      sfrRdata[BIT_DTH_HI:BIT_DTH_LO] = ctl_ff.dTh;
      sfrRdata[BIT_ATH_HI:BIT_ATH_LO] = ctl_ff.aTh;
      sfrRdata[BIT_ENABLE] = ctl_ff.en;
   end

   assign digThreshold    = ctl_ff.dTh;
   assign analogThreshold = ctl_ff.aTh;
   assign monitorEnable   = ctl_ff.en;
   assign supplyFailIrq   = ctl_ff.flag && secondaryIrqEnablePriority;
endmodule

// file: sim/psm_supply_monitor_asserts.sv
/*
 Checker of the supply monitor flag logic: flag, filter, recovery, register.
 Assumes the bench sets GLITCH_CYC to 3 and a short RECOVER_CYC.
*/
module psm_supply_monitor_asserts
   import psm_pkg::*;
#(
   parameter longint RECOVER_CYC = 20,
   parameter int     GLITCH_CYC  = 3
) (
   input wire logic         clk,
   input wire logic         rst,
   input wire psm_sfr_req_s sfrReq,
   input wire logic [7:0]   sfrRdata,
   input wire psm_cmp_s     cmpRaw,
   input wire logic [1:0]   digThreshold,
   input wire logic [1:0]   analogThreshold,
   input wire logic         monitorEnable,
   input wire logic         secondaryIrqEnablePriority,
   input wire logic         supplyFailIrq
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // ------------------------------------------------------------
   // Cycles spent enabled with both rails good
   // ------------------------------------------------------------
   int okRun_ff;
   always_ff @(posedge clk) begin
      if (rst || !(monitorEnable && sfrRdata[7] && sfrRdata[6]))
         okRun_ff <= 0;
      else if (okRun_ff < RECOVER_CYC + 8)
         okRun_ff <= okRun_ff + 1;
   end

   sequence s_dig_blip;
      sfrRdata[7] && $fell(cmpRaw.digOk) ##1 cmpRaw.digOk;
   endsequence

   a_irq_gate: assert property (
      supplyFailIrq == (sfrRdata[5] && secondaryIrqEnablePriority))
      else $error("irq not flag and enable");
   a_flag_set: assert property (
      monitorEnable && !(sfrRdata[7] && sfrRdata[6]) |=> sfrRdata[5])
      else $error("flag not set on low rail");
   a_dig_filter: assert property ((!cmpRaw.digOk) [*4] |=> !sfrRdata[7])
      else $error("digital status not following");
   a_ana_filter: assert property ((cmpRaw.anaOk) [*4] |=> sfrRdata[6])
      else $error("analog status not following");
   a_blip_block: assert property (s_dig_blip |=> sfrRdata[7] [*2])
      else $error("glitch passed filter");
   a_no_early: assert property (
      sfrRdata[5] && okRun_ff < RECOVER_CYC && !sfrReq.wrEn |=> sfrRdata[5])
      else $error("flag cleared early");
   a_recover_clr: assert property (okRun_ff == RECOVER_CYC + 6 |-> !sfrRdata[5])
      else $error("flag not cleared after recovery");
   a_off_hold: assert property (
      !monitorEnable && !sfrRdata[5] && !sfrReq.wrEn |=> !sfrRdata[5])
      else $error("flag set while disabled");
   a_write_take: assert property (
      sfrReq.wrEn && sfrReq.addr == PSM_CTRL_ADDR |=>
      {digThreshold, analogThreshold, monitorEnable} == $past(sfrReq.wdata[4:0]))
      else $error("write not taken");
endmodule

bind psm_supply_monitor psm_supply_monitor_asserts #(
   .RECOVER_CYC(RECOVER_CYC), .GLITCH_CYC(GLITCH_CYC)) u_psm_supply_monitor_asserts (
   .clk(clk), .rst(rst), .sfrReq(sfrReq), .sfrRdata(sfrRdata), .cmpRaw(cmpRaw),
   .digThreshold(digThreshold), .analogThreshold(analogThreshold),
   .monitorEnable(monitorEnable), .secondaryIrqEnablePriority(secondaryIrqEnablePriority),
   .supplyFailIrq(supplyFailIrq));

// file: sim/tb.sv
/*
 Self-checking bench of the supply monitor flag logic.
 Assumes the design and its bound checker are compiled before it.
*/
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import psm_pkg::*;

   localparam int RCY = 20;
   logic         clk;
   logic         rst;
   logic         ien;
   logic         irq;
   logic         en;
   logic [1:0]   dth;
   logic [1:0]   ath;
   logic [7:0]   rd;
   psm_sfr_req_s req;
   psm_cmp_s     cmp;
   int           bad_count;
   int           num_checks;

   psm_supply_monitor #(.RECOVER_CYC(RCY), .GLITCH_CYC(3)) u_psm_supply_monitor (
      .clk(clk), .rst(rst), .sfrReq(req), .sfrRdata(rd), .cmpRaw(cmp),
      .digThreshold(dth), .analogThreshold(ath), .monitorEnable(en),
      .secondaryIrqEnablePriority(ien), .supplyFailIrq(irq));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req = '{wrEn: 1'b1, addr: a, wdata: d};
      wt(1);
      req.wrEn = 1'b0;
      wt(1);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      #40000;
      bad_count++;
      final_report();
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      ien = 1'b0;
      req = '0;
      cmp = '{digOk: 1'b1, anaOk: 1'b1};
      bad_count = 0;
      num_checks = 0;
      wt(5);
      rst = 1'b0;
      chk(rd, PSM_CTRL_RESET);
      for (int i = 0; i < 4; i++) begin
         wr(PSM_CTRL_ADDR, {3'h0, 2'(i), 2'(i), 1'b0});
         chk(rd, {3'h6, 2'(i), 2'(i), 1'b0});
         chk({3'h0, dth, ath, en}, {3'h0, 2'(i), 2'(i), 1'b0});
      end
      wr(8'h00, 8'h01);
      chk(rd, 8'hDE);
      cmp.digOk = 1'b0;
      wt(8);
      chk(rd, 8'h5E);
      cmp.digOk = 1'b1;
      wt(8);
      $display("register and disabled tests done");
      wr(PSM_CTRL_ADDR, 8'h01);
      cmp.digOk = 1'b0;
      wt(1);
      cmp.digOk = 1'b1;
      wt(6);
      chk(rd, 8'hC1);
      cmp.anaOk = 1'b0;
      wt(8);
      chk(rd, 8'hA1);
      ien = 1'b1;
      wt(1);
      chk({7'h00, irq}, 8'h01);
      ien = 1'b0;
      wt(1);
      chk({7'h00, irq}, 8'h00);
      wr(PSM_CTRL_ADDR, 8'h01);
      chk(rd, 8'hA1);
      $display("flag set tests done");
      cmp.anaOk = 1'b1;
      wt(15);
      cmp.digOk = 1'b0;
      wt(6);
      cmp.digOk = 1'b1;
      wt(12);
      chk(rd, 8'hE1);
      wt(20);
      chk(rd, 8'hC1);
      wt(10);
      wr(PSM_CTRL_ADDR, 8'h21);
      chk(rd, 8'hE1);
      wr(PSM_CTRL_ADDR, 8'h01);
      chk(rd, 8'hC1);
      $display("recovery tests done");
      wr(PSM_CTRL_ADDR, 8'h20);
      cmp.anaOk = 1'b0;
      wt(RCY + 10);
      chk(rd, 8'hA0);
      wr(PSM_CTRL_ADDR, 8'h00);
      chk(rd, 8'hA0);
      cmp.anaOk = 1'b1;
      wt(RCY + 10);
      chk(rd, 8'hE0);
      rst = 1'b1;
      wt(5);
      rst = 1'b0;
      chk(rd, PSM_CTRL_RESET);
      $display("disable and reset tests done");
      final_report();
   end
endmodule
